/* verilog/sfc_capture_top.sv */
`timescale 1ns/10ps
module sfc_capture_top #(
    parameter int unsigned ADDR_W = 19
) (
    input  wire logic           clock_in,
    input  wire logic           nrst_in,
    input  wire logic           spi_sclk_in,
    input  wire logic           spi_cs_n_in,
    input  wire logic           spi_mosi_in,
    output logic                spi_miso_out,
    input  wire sfc_pkg::sfc_sensor_t sen_in,
    output logic                sen_pwdn_out,
    output logic                mem_sleep_out,
    output logic                cap_done_out,
    output logic                cap_busy_out,
    output logic                low_power_out
);
    import sfc_pkg::*;

    if (ADDR_W < 4 || ADDR_W > 24) begin : g_chk
        $error("sfc_capture_top: ADDR_W out of range");
    end

    localparam int unsigned SYNC_W = 2 + $bits(sfc_sensor_t);

    ////////////////////////////////////////////////////////////////////////
    // link domain: SPI slave, mode 0, msb first
    logic [2:0]        bit_cnt_ff, nxt_bit_cnt;
    logic [6:0]        shift_ff, nxt_shift;
    logic [7:0]        cmd_ff, nxt_cmd;
    logic              phase_ff, nxt_phase;
    logic              data_seen_ff, nxt_data_seen;
    logic [7:0]        rx_byte;
    logic              byte_end;
    logic [7:0]        out_ff, nxt_out;
    logic              rd_tgl_ff, nxt_rd_tgl;
    logic              wr_tgl_ff, nxt_wr_tgl;
    sfc_hostcmd_t      hcmd_ff, nxt_hcmd;
    logic [STAT_W-1:0] st_s1_ff, st_s2_ff, st_s3_ff, st_f_ff, nxt_st_f;
    logic [STAT_W-1:0] status_flags;
    logic [7:0]        rd_byte;
    logic              give_image;

    assign rx_byte  = {shift_ff, spi_mosi_in};
    assign byte_end = (bit_cnt_ff == 3'h7);

    always_comb begin
        nxt_bit_cnt   = bit_cnt_ff + 3'h1;
        nxt_shift     = rx_byte[6:0];
        nxt_cmd       = cmd_ff;
        nxt_phase     = phase_ff;
        nxt_data_seen = data_seen_ff;
        if (byte_end) begin
            if (!phase_ff) begin
                nxt_cmd   = rx_byte;
                nxt_phase = 1'b1;
            end else begin
                nxt_data_seen = 1'b1;
            end
        end
    end

    // deselect clears the frame state; the clock may be parked between
    always_ff @(posedge spi_sclk_in or posedge spi_cs_n_in) begin
        if (spi_cs_n_in) begin
            bit_cnt_ff   <= 3'h0;
            shift_ff     <= 7'h00;
            cmd_ff       <= 8'h00;
            phase_ff     <= 1'b0;
            data_seen_ff <= 1'b0;
        end else begin
            bit_cnt_ff   <= nxt_bit_cnt;
            shift_ff     <= nxt_shift;
            cmd_ff       <= nxt_cmd;
            phase_ff     <= nxt_phase;
            data_seen_ff <= nxt_data_seen;
        end
    end

    // argument commands: word held stable, announced by a toggle
    always_comb begin
        nxt_hcmd   = hcmd_ff;
        nxt_wr_tgl = wr_tgl_ff;
        if (byte_end && phase_ff && !data_seen_ff && cmd_ff[7]) begin
            nxt_hcmd.op  = cmd_ff[6:0];
            nxt_hcmd.arg = rx_byte;
            nxt_wr_tgl   = ~wr_tgl_ff;
        end
        nxt_st_f = (st_s2_ff == st_s3_ff) ? st_s3_ff : st_f_ff;
    end

    // status enters the link domain through three flops
    // the read toggle fires on the rising edge that samples the first bit
    // of a loaded image byte; mode 0 always ends on a falling edge, and a
    // toggle there would skip a byte that nobody clocked out
    always_ff @(posedge spi_sclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hcmd_ff   <= '0;
            wr_tgl_ff <= 1'b0;
            rd_tgl_ff <= 1'b0;
            st_s1_ff  <= '0;
            st_s2_ff  <= '0;
            st_s3_ff  <= '0;
            st_f_ff   <= '0;
        end else begin
            hcmd_ff   <= nxt_hcmd;
            wr_tgl_ff <= nxt_wr_tgl;
            rd_tgl_ff <= nxt_rd_tgl;
            st_s1_ff  <= status_flags;
            st_s2_ff  <= st_s1_ff;
            st_s3_ff  <= st_s2_ff;
            st_f_ff   <= nxt_st_f;
        end
    end

    // single read hands out only the first data byte
    assign give_image = (cmd_ff == CMD_RD_BURST) ||
                        (cmd_ff == CMD_RD_SINGLE && !data_seen_ff);

    always_comb begin
        nxt_out    = {out_ff[6:0], 1'b0};
        nxt_rd_tgl = rd_tgl_ff;
        if (phase_ff && bit_cnt_ff == 3'h0) begin
            if (cmd_ff == CMD_RD_STATUS) begin
                nxt_out = {{(8 - STAT_W){1'b0}}, st_f_ff};
            end else if (give_image) begin
                nxt_out    = rd_byte;
                nxt_rd_tgl = ~rd_tgl_ff;
            end else begin
                nxt_out = 8'h00;
            end
        end
    end

    // miso changes on the falling edge so the master samples on rising
    always_ff @(negedge spi_sclk_in or posedge spi_cs_n_in) begin
        if (spi_cs_n_in) begin
            out_ff <= 8'h00;
        end else begin
            out_ff <= nxt_out;
        end
    end

    assign spi_miso_out = out_ff[7];

    ////////////////////////////////////////////////////////////////////////
    // system domain: pin and toggle inputs, three flops, filtered
    logic [SYNC_W-1:0] s1_ff, s2_ff, s3_ff;
    logic [SYNC_W-1:0] filt_ff, nxt_filt, prev_ff;
    sfc_sensor_t       sen_f, sen_p;
    logic              wr_evt, rd_evt, vs_rise, pclk_rise;

    always_comb begin
        for (int i = 0; i < SYNC_W; i++) begin
            nxt_filt[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : filt_ff[i];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            s1_ff   <= '0;
            s2_ff   <= '0;
            s3_ff   <= '0;
            filt_ff <= '0;
            prev_ff <= '0;
        end else begin
            s1_ff   <= {wr_tgl_ff, rd_tgl_ff, sen_in};
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            filt_ff <= nxt_filt;
            prev_ff <= filt_ff;
        end
    end

    // sensor pixel clock must be well below a quarter of clock_in
    assign sen_f     = filt_ff[SYNC_W-3:0];
    assign sen_p     = prev_ff[SYNC_W-3:0];
    assign wr_evt    = filt_ff[SYNC_W-1] ^ prev_ff[SYNC_W-1];
    assign rd_evt    = filt_ff[SYNC_W-2] ^ prev_ff[SYNC_W-2];
    assign vs_rise   = sen_f.vsync & ~sen_p.vsync;
    assign pclk_rise = sen_f.pclk & ~sen_p.pclk;

    ////////////////////////////////////////////////////////////////////////
    // capture control and buffer pointers
    sfc_cap_st_t       state_ff, nxt_state;
    logic [FCNT_W-1:0] fcnt_ff, nxt_fcnt, left_ff, nxt_left;
    logic [ADDR_W-1:0] wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
    logic              done_ff, nxt_done, lp_ff, nxt_lp;
    logic              mem_we;
    logic              do_start;
    sfc_hostcmd_t      hcmd_s;

    // word was stable long before its toggle got through the flops
    assign hcmd_s = hcmd_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_fcnt  = fcnt_ff;
        nxt_left  = left_ff;
        nxt_wptr  = wptr_ff;
        nxt_rptr  = rptr_ff;
        nxt_done  = done_ff;
        nxt_lp    = lp_ff;
        mem_we    = 1'b0;
        do_start  = 1'b0;
        if (rd_evt) begin
            nxt_rptr = rptr_ff + 1'b1;
        end
        if (wr_evt) begin
            unique case (hcmd_s.op)
                CMD_WR_CAPT[6:0]: begin
                    nxt_fcnt = hcmd_s.arg[FCNT_W-1:0];
                end
                CMD_WR_POWER[6:0]: begin
                    nxt_lp = hcmd_s.arg[PWR_LOW_POS];
                end
                CMD_WR_CTRL[6:0]: begin
                    if (hcmd_s.arg[CTL_CLEAR_POS]) begin
                        nxt_done = 1'b0;
                    end
                    if (hcmd_s.arg[CTL_REWIND_POS]) begin
                        nxt_rptr = '0;
                    end
                    do_start = hcmd_s.arg[CTL_START_POS];
                end
                default: ;
            endcase
        end
        unique case (state_ff)
            CAP_IDLE: begin
                if (do_start && !nxt_lp) begin
                    // a count of zero is taken as a single frame
                    nxt_left  = (fcnt_ff == '0) ? FCNT_RST : fcnt_ff;
                    nxt_wptr  = '0;
                    nxt_rptr  = '0;
                    nxt_done  = 1'b0;
                    nxt_state = CAP_ARM;
                end
            end
            CAP_ARM: begin
                if (vs_rise) begin
                    nxt_state = CAP_FRAME;
                end
            end
            CAP_FRAME: begin
                if (vs_rise) begin
                    if (left_ff == FCNT_RST) begin
                        nxt_state = CAP_IDLE;
                        nxt_done  = 1'b1;
                    end else begin
                        nxt_left = left_ff - 1'b1;
                    end
                end else if (pclk_rise && sen_f.href) begin
                    mem_we = 1'b1;
                    // full buffer: last byte is overwritten, not wrapped
                    if (wptr_ff != '1) begin
                        nxt_wptr = wptr_ff + 1'b1;
                    end
                end
            end
            default: nxt_state = CAP_IDLE;
        endcase
        if (nxt_lp) begin
            nxt_state = CAP_IDLE;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            state_ff <= CAP_IDLE;
            fcnt_ff  <= FCNT_RST;
            left_ff  <= FCNT_RST;
            wptr_ff  <= '0;
            rptr_ff  <= '0;
            done_ff  <= 1'b0;
            lp_ff    <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            fcnt_ff  <= nxt_fcnt;
            left_ff  <= nxt_left;
            wptr_ff  <= nxt_wptr;
            rptr_ff  <= nxt_rptr;
            done_ff  <= nxt_done;
            lp_ff    <= nxt_lp;
        end
    end

    sfc_frame_mem #(
        .ADDR_W (ADDR_W),
        .DATA_W (8)
    ) u_mem (
        .clock_in  (clock_in),
        .we_in     (mem_we),
        .waddr_in  (wptr_ff),
        .wdata_in  (sen_f.data),
        .raddr_in  (rptr_ff),
        .rdata_out (rd_byte)
    );

    always_comb begin
        status_flags                = '0;
        status_flags[STAT_DONE_POS] = done_ff;
        status_flags[STAT_BUSY_POS] = (state_ff != CAP_IDLE);
        status_flags[STAT_LOW_POS]  = lp_ff;
    end

    assign sen_pwdn_out  = lp_ff;
    assign mem_sleep_out = lp_ff;
    assign cap_done_out  = done_ff;
    assign cap_busy_out  = (state_ff != CAP_IDLE);
    assign low_power_out = lp_ff;

endmodule : sfc_capture_top

/* verilog/sfc_pkg.sv */
package sfc_pkg;

    localparam int unsigned BUF_ADDR_W = 19;
    localparam int unsigned FCNT_W     = 3;
    localparam logic [FCNT_W-1:0] FCNT_RST = 3'h1;

    // command byte; bit 7 set means one argument byte follows
    localparam logic [7:0] CMD_RD_STATUS = 8'h41;
    localparam logic [7:0] CMD_RD_SINGLE = 8'h3D;
    localparam logic [7:0] CMD_RD_BURST  = 8'h3C;
    localparam logic [7:0] CMD_WR_CAPT   = 8'h81;
    localparam logic [7:0] CMD_WR_POWER  = 8'h82;
    localparam logic [7:0] CMD_WR_CTRL   = 8'h84;

    // argument bits of the control command
    localparam int unsigned CTL_CLEAR_POS  = 0;
    localparam int unsigned CTL_START_POS  = 1;
    localparam int unsigned CTL_REWIND_POS = 2;
    // argument bit of the power command
    localparam int unsigned PWR_LOW_POS    = 0;
    // status byte layout
    localparam int unsigned STAT_DONE_POS  = 0;
    localparam int unsigned STAT_BUSY_POS  = 1;
    localparam int unsigned STAT_LOW_POS   = 2;
    localparam int unsigned STAT_W         = 3;

    typedef enum logic [1:0] {
        CAP_IDLE  = 2'b00,
        CAP_ARM   = 2'b01,
        CAP_FRAME = 2'b10
    } sfc_cap_st_t;

    typedef struct packed {
        logic       vsync;
        logic       href;
        logic       pclk;
        logic [7:0] data;
    } sfc_sensor_t;

    typedef struct packed {
        logic [6:0] op;
        logic [7:0] arg;
    } sfc_hostcmd_t;

endpackage : sfc_pkg

/* verilog/sfc_frame_mem.sv */
`timescale 1ns/10ps
module sfc_frame_mem #(
    parameter int unsigned ADDR_W = 19,
    parameter int unsigned DATA_W = 8
) (
    input  wire logic              clock_in,
    input  wire logic              we_in,
    input  wire logic [ADDR_W-1:0] waddr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    input  wire logic [ADDR_W-1:0] raddr_in,
    output logic      [DATA_W-1:0] rdata_out
);
    if (ADDR_W < 4 || ADDR_W > 24 || DATA_W < 1) begin : g_chk
        $error("sfc_frame_mem: unsupported size");
    end

    logic [DATA_W-1:0] mem_ff [2**ADDR_W];

    // read data registered; no reset so it maps onto block memory
    always_ff @(posedge clock_in) begin
        if (we_in) begin
            mem_ff[waddr_in] <= wdata_in;
        end
        rdata_out <= mem_ff[raddr_in];
    end

endmodule : sfc_frame_mem

/* dv/sfc_capture_asserts.sv */
`timescale 1ns/10ps
module sfc_capture_asserts
    import sfc_pkg::*;
#(
    parameter int unsigned ADDR_W = 19
) (
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    input  wire logic        spi_cs_n_in,
    input  wire logic        spi_miso_out,
    input  wire sfc_sensor_t sen_in,
    input  wire logic        sen_pwdn_out,
    input  wire logic        mem_sleep_out,
    input  wire logic        cap_done_out,
    input  wire logic        cap_busy_out,
    input  wire logic        low_power_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);
    ////////////////////////////////////////////////////////////////////
    // cycles since the raw sensor frame edge; saturates so it never wraps
    logic       vs_q_ff;
    logic [3:0] vs_age_ff;
    logic [3:0] nxt_vs_age;
    always_comb begin
        nxt_vs_age = vs_age_ff + ((vs_age_ff == 4'hF) ? 4'h0 : 4'h1);
        if (sen_in.vsync && !vs_q_ff) begin
            nxt_vs_age = 4'h0;
        end
    end
    always_ff @(posedge clock_in) begin
        vs_q_ff   <= sen_in.vsync;
        vs_age_ff <= nrst_in ? nxt_vs_age : 4'hF;
    end
    ////////////////////////////////////////////////////////////////////
    sequence s_armed;
        $rose(cap_busy_out);
    endsequence
    chk_reset_quiet: assert property (
        $rose(nrst_in) |-> !cap_done_out && !cap_busy_out && !low_power_out)
        else $error("outputs not idle after reset");
    chk_frame_edge: assert property (
        $rose(cap_done_out) |-> vs_age_ff <= 4'hA)
        else $error("capture ended away from a frame edge");
    chk_done_cause: assert property (
        $rose(cap_done_out) |-> $past(cap_busy_out))
        else $error("done set without a capture");
    chk_busy_end: assert property (
        $fell(cap_busy_out) && !low_power_out |-> ##[0:1] cap_done_out)
        else $error("capture finished without done");
    chk_start_clear: assert property (
        s_armed |-> !cap_done_out [*8])
        else $error("done seen early in a new capture");
    chk_power_follow: assert property (
        sen_pwdn_out == low_power_out && mem_sleep_out == low_power_out)
        else $error("power down outputs disagree");
    chk_power_abort: assert property (
        $rose(low_power_out) |-> ##[0:4] !cap_busy_out)
        else $error("capture kept running in low power");
    chk_miso_idle: assert property (
        spi_cs_n_in && $past(spi_cs_n_in) |-> !spi_miso_out)
        else $error("miso driven while deselected");
endmodule : sfc_capture_asserts

/* dv/sfc_host_model.sv */
`timescale 1ns/10ps
module sfc_host_model (
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      mosi_out,
    input  wire logic miso_in
);
    logic [7:0] rx_q[$];
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // one frame per call: command then data bytes, msb first, mode 0
    task automatic xfer(input logic [7:0] tx[$]);
        logic [7:0] b;
        rx_q = {};
        cs_n_out = 1'b0;
        foreach (tx[k]) begin
            for (int i = 7; i >= 0; i--) begin
                mosi_out = tx[k][i];
                #6;
                b[i] = miso_in;
                sclk_out = 1'b1;
                #6;
                sclk_out = 1'b0;
            end
            rx_q.push_back(b);
        end
        #6;
        cs_n_out = 1'b1;
        // released line must not keep showing the last bit
        mosi_out = ~mosi_out;
        #60;
    endtask : xfer
endmodule : sfc_host_model

/* dv/sfc_capture_tb.sv */
`timescale 1ns/10ps
module sfc_capture_tb;
    import sfc_pkg::*;
    logic        clock_in = 1'b0;
    logic        nrst_in  = 1'b1;
    logic        sclk;
    logic        cs_n;
    logic        mosi;
    logic        miso;
    logic        pwdn;
    logic        msleep;
    logic        done;
    logic        busy;
    logic        lowp;
    sfc_sensor_t sen      = '0;
    int          fails    = 0;
    int          checks   = 0;
    always #4 clock_in = ~clock_in;
    sfc_host_model sfc_host_model_inst (.sclk_out(sclk), .cs_n_out(cs_n),
        .mosi_out(mosi), .miso_in(miso));
    sfc_capture_top #(.ADDR_W(8)) sfc_capture_top_inst (.clock_in(clock_in),
        .nrst_in(nrst_in), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n),
        .spi_mosi_in(mosi), .spi_miso_out(miso), .sen_in(sen),
        .sen_pwdn_out(pwdn), .mem_sleep_out(msleep), .cap_done_out(done),
        .cap_busy_out(busy), .low_power_out(lowp));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : tick
    // command effects land a few system cycles after the frame closes
    task automatic spi(input logic [7:0] op, input logic [7:0] a, input int n);
        logic [7:0] q[$];
        q = {op};
        repeat (n) q.push_back(a);
        tick(1);
        sfc_host_model_inst.xfer(q);
        tick(10);
    endtask : spi
    task automatic poll(input logic [7:0] exp);
        for (int k = 0; k < 40; k++) begin
            spi(CMD_RD_STATUS, 8'h00, 1);
            if (sfc_host_model_inst.rx_q[1] === exp) break;
        end
        check(sfc_host_model_inst.rx_q[1], exp);
    endtask : poll
    task automatic burst(input logic [7:0] base);
        spi(CMD_RD_BURST, 8'h00, 4);
        for (int k = 0; k < 4; k++) begin
            check(sfc_host_model_inst.rx_q[k+1], base + 8'(k));
        end
    endtask : burst
    task automatic vs_pulse();
        tick(1);
        sen.vsync = 1'b1;
        tick(8);
        sen.vsync = 1'b0;
        tick(8);
    endtask : vs_pulse
    // pclk near 10 MHz keeps the sampled sensor pins well resolved
    task automatic line(input logic [7:0] base, input int n);
        for (int i = 0; i < n; i++) begin
            tick(1);
            sen.href = 1'b1;
            sen.data = base + 8'(i);
            tick(6);
            sen.pclk = 1'b1;
            tick(6);
            sen.pclk = 1'b0;
        end
        tick(1);
        sen.href = 1'b0;
    endtask : line
    task automatic finish_test();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        fails++;
        finish_test();
    end
    initial begin
        // a real falling edge, so the link-side async clears do fire
        #1;
        nrst_in = 1'b0;
        tick(3);
        nrst_in = 1'b1;
        tick(8);
        check({5'h00, lowp, busy, done}, 8'h00);
        poll(8'h00);
        spi(CMD_WR_CTRL, 8'h02, 1);
        check({5'h00, lowp, busy, done}, 8'h02);
        vs_pulse();
        line(8'h10, 4);
        vs_pulse();
        line(8'h20, 4);
        poll(8'h01);
        spi(CMD_RD_SINGLE, 8'h00, 2);
        check(sfc_host_model_inst.rx_q[1], 8'h10);
        check(sfc_host_model_inst.rx_q[2], 8'h00);
        spi(CMD_RD_SINGLE, 8'h00, 1);
        check(sfc_host_model_inst.rx_q[1], 8'h11);
        spi(CMD_WR_CTRL, 8'h04, 1);
        burst(8'h10);
        spi(CMD_WR_CTRL, 8'h01, 1);
        poll(8'h00);
        spi(CMD_WR_CAPT, 8'h02, 1);
        spi(CMD_WR_CTRL, 8'h02, 1);
        vs_pulse();
        line(8'h30, 2);
        vs_pulse();
        check({5'h00, lowp, busy, done}, 8'h02);
        line(8'h32, 2);
        vs_pulse();
        poll(8'h01);
        spi(CMD_WR_CTRL, 8'h04, 1);
        burst(8'h30);
        spi(CMD_WR_POWER, 8'h01, 1);
        check({5'h00, pwdn, msleep, lowp}, 8'h07);
        spi(CMD_WR_CTRL, 8'h02, 1);
        check({7'h00, busy}, 8'h00);
        spi(CMD_WR_POWER, 8'h00, 1);
        check({5'h00, pwdn, msleep, lowp}, 8'h00);
        finish_test();
    end
endmodule : sfc_capture_tb
bind sfc_capture_top sfc_capture_asserts #(.ADDR_W(ADDR_W))
    sfc_capture_asserts_inst (.clock_in(clock_in), .nrst_in(nrst_in),
    .spi_cs_n_in(spi_cs_n_in), .spi_miso_out(spi_miso_out), .sen_in(sen_in),
    .sen_pwdn_out(sen_pwdn_out), .mem_sleep_out(mem_sleep_out),
    .cap_done_out(cap_done_out), .cap_busy_out(cap_busy_out),
    .low_power_out(low_power_out));
